// ==== flash_lock_defines.vh ====
// Purpose: constants for the flash protection block
// Assumes: included by flash_lock_security_nvm.v
// Notes: definitions only
`ifndef FLASH_LOCK_DEFINES_VH
`define FLASH_LOCK_DEFINES_VH
// command codes
`define CMD_READ_DESC 4'h0
`define CMD_PROG_PAGE 4'h1
`define CMD_ERASE_PAGE 4'h2
`define CMD_ERASE_ALL 4'h3
`define CMD_SET_LOCK 4'h4
`define CMD_CLR_LOCK 4'h5
`define CMD_SET_GPBIT 4'h6
`define CMD_CLR_GPBIT 4'h7
// organisation
`define PAGES_PER_REGION 32
`define PAGE_BYTES 256
`define REGIONS_LARGE 16
`define REGIONS_SMALL 8
`define WBUF_BYTES 128
`define WBUF_WORDS 32
`define ARRAY_BITS 128
// general nonvolatile bit positions
`define GPBIT_SECURITY 0
`define GPBIT_BOOT 1
// erase pin hold time
`define ERASE_HOLD_MS 200
`define CLK_MHZ 50
`define ERASE_HOLD_CYC (`ERASE_HOLD_MS * 1000 * `CLK_MHZ)
`endif

// ==== flash_lock_security_nvm.v ====
// Purpose: flash lock, security, boot-select and fast programming entry logic
// Assumes: single clock sys_clk, synchronous active-low reset, inputs synchronous
// Notes: array operations are requested to the flash array by a start/done handshake
//
// Contract
// R1: large variant keeps sixteen lock bits, each guarding thirty-two 256-byte pages
// R2: small variant keeps eight lock bits, each guarding thirty-two pages
// R3: erase or program into a locked region is aborted and raises interrupt
// R4: set-lock command sets region lock bit, clear-lock command clears it
// R5: erase pin clears every lock bit
// R6: security bit set refuses debug and fast-programming flash access
// R7: software commands can only set the security bit, never clear it
// R8: security clears only with erase pin high and full erase completed; the code also accepts the pin seen high since the last erase-all
// R9: external agent holds erase pin asserted longer than 200 ms
// R10: calibration bits are fixed and unaffected by erase pin
// R11: two general nonvolatile bits with set and clear commands
// R12: test pin and clock input high with wakeup low enter fast programming
// R13: fast programming port accepts read, program, erase, lock, unlock, protect
// R14: a 128-byte write buffer filled by 32-bit writes before programming
// R15: with boot bit zero the boot ROM appears at address zero
// R16: flash fetched 128 bits wide while serving a 32-bit bus
// R17: one command returns a descriptor of flash organisation
// R18: boot bit set selects flash boot; erase pin clears it
// R19: an aborted command leaves array and nonvolatile bits unchanged
`timescale 1ns/1ps
`include "flash_lock_defines.vh"
`default_nettype none
module flash_lock_security_nvm #(
  parameter REGIONS = `REGIONS_LARGE,
  parameter PAGE_AW = 9,
  parameter [31:0] ERASE_HOLD_CYC = `ERASE_HOLD_CYC,
  parameter [7:0] CAL_BITS = 8'h5a
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  // software command port
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [PAGE_AW-1:0] cmd_arg,
  input wire cmd_from_fast,
  output wire cmd_ready,
  output reg cmd_done,
  output reg cmd_abort,
  output reg irq,
  output reg [31:0] cmd_result,
  // write buffer fill, 32-bit
  input wire wbuf_we,
  input wire [4:0] wbuf_addr,
  input wire [31:0] wbuf_wdata,
  // bus read port, 32-bit
  input wire rd_req,
  input wire rd_debug,
  input wire rd_fast,
  input wire [31:0] rd_addr,
  output reg rd_valid,
  output reg rd_denied,
  output reg [31:0] rd_data,
  output reg rd_from_rom,
  // flash array, 128-bit
  output reg arr_start,
  output reg [1:0] arr_op,
  output reg [PAGE_AW-1:0] arr_page,
  output reg [127:0] arr_wdata,
  output reg [2:0] arr_wsel,
  output reg arr_rd,
  output reg [31:0] arr_raddr,
  input wire [127:0] arr_rdata,
  input wire arr_done,
  // pins
  input wire erase_pin,
  input wire test_mode_pin,
  input wire external_clock_input,
  input wire force_wakeup_pin,
  // status
  output wire [REGIONS-1:0] lock_bits,
  output wire [1:0] general_nonvolatile_bits,
  output wire [7:0] calibration_bits,
  output reg fast_prog_mode,
  output wire boot_from_flash
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RDWAIT = 2'd2;
  localparam RGN_SHIFT = 5;

  reg [REGIONS-1:0] lock_reg;
  reg [1:0] gp_reg;
  reg [1:0] st_reg;
  reg [31:0] wbuf_reg [0:`WBUF_WORDS-1];
  reg [31:0] hold_cnt_reg;
  reg erase_armed_reg;
  reg [3:0] op_reg;
  reg [1:0] rd_word_reg;
  reg rd_deny_pending;

  assign lock_bits = lock_reg;
  assign general_nonvolatile_bits = gp_reg;
  assign calibration_bits = CAL_BITS; // [R10]
  assign boot_from_flash = gp_reg[`GPBIT_BOOT]; // [R18]
  assign cmd_ready = (st_reg == ST_IDLE) && !rd_req;

  // region index of a page
  function [3:0] region_of;
    input [PAGE_AW-1:0] pg;
    begin
      region_of = pg[PAGE_AW-1:RGN_SHIFT]; // [R1] [R2]
    end
  endfunction

  function is_locked;
    input [PAGE_AW-1:0] pg;
    input [REGIONS-1:0] lk;
    begin
      is_locked = lk[region_of(pg)];
    end
  endfunction

  wire is_array_op = (cmd_code == `CMD_PROG_PAGE) || (cmd_code == `CMD_ERASE_PAGE);
  wire fast_blocked = cmd_from_fast && gp_reg[`GPBIT_SECURITY];
  wire locked_hit = is_array_op && is_locked(cmd_arg, lock_reg);
  // descriptor fields cut to their slot widths
  localparam [7:0] DESC_REGIONS = REGIONS[7:0];
  localparam [15:0] DESC_PAGE_BYTES = 16'd`PAGE_BYTES;
  wire [31:0] descriptor = {8'h00, DESC_REGIONS, DESC_PAGE_BYTES};

  // an erase-all finishing this cycle
  wire full_erase_end = clk_en && (st_reg == ST_WAIT) && arr_done
    && (op_reg == `CMD_ERASE_ALL);

  // one 32-bit word out of a 128-bit array line
  function [31:0] pick_word;
    input [127:0] line;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: pick_word = line[31:0];
        2'd1: pick_word = line[63:32];
        2'd2: pick_word = line[95:64];
        default: pick_word = line[127:96];
      endcase
    end
  endfunction

  // first four buffer words form the program line, word 0 lowest
  function [127:0] buf_line;
    input [31:0] w0;
    input [31:0] w1;
    input [31:0] w2;
    input [31:0] w3;
    begin
      buf_line = {w3, w2, w1, w0}; // [R14]
    end
  endfunction

  // low megabyte of the map, where the boot rom shows while the boot bit is 0
  function in_low_window;
    input [31:0] addr;
    begin
      in_low_window = (addr[31:20] == 12'h000); // [R15]
    end
  endfunction

  // ----------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `WBUF_WORDS; gi = gi + 1) begin : g_wbuf
      always @(posedge sys_clk) begin
        if (!rst_b) begin
          wbuf_reg[gi] <= 32'h0000_0000;
        end else if (clk_en && wbuf_we && wbuf_addr == gi) begin
          wbuf_reg[gi] <= wbuf_wdata; // [R14]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // command sequencer and nonvolatile bits
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      lock_reg <= {REGIONS{1'b0}};
      gp_reg <= 2'b00;
      st_reg <= ST_IDLE;
      cmd_done <= 1'b0;
      cmd_abort <= 1'b0;
      irq <= 1'b0;
      cmd_result <= 32'h0000_0000;
      arr_start <= 1'b0;
      arr_op <= 2'd0;
      arr_page <= {PAGE_AW{1'b0}};
      arr_wdata <= 128'h0;
      arr_wsel <= 3'd0;
      arr_rd <= 1'b0;
      arr_raddr <= 32'h0000_0000;
      rd_valid <= 1'b0;
      rd_denied <= 1'b0;
      rd_data <= 32'h0000_0000;
      rd_from_rom <= 1'b0;
      op_reg <= 4'h0;
      rd_word_reg <= 2'd0;
      rd_deny_pending <= 1'b0;
    end else if (clk_en) begin
      cmd_done <= 1'b0;
      cmd_abort <= 1'b0;
      irq <= 1'b0;
      arr_start <= 1'b0;
      arr_rd <= 1'b0;
      rd_valid <= 1'b0;
      rd_denied <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (rd_req) begin
            if ((rd_debug || rd_fast) && gp_reg[`GPBIT_SECURITY]) begin
              rd_denied <= 1'b1; // [R6]
            end else begin
              arr_rd <= 1'b1; // [R16]
              arr_raddr <= {rd_addr[31:4], 4'h0};
              rd_word_reg <= rd_addr[3:2];
              rd_from_rom <= !gp_reg[`GPBIT_BOOT] && in_low_window(rd_addr); // [R15]
              st_reg <= ST_RDWAIT;
            end
          end else if (cmd_valid) begin
            op_reg <= cmd_code;
            if (fast_blocked) begin
              cmd_abort <= 1'b1; // [R6]
              cmd_done <= 1'b1;
            end else if (locked_hit) begin
              cmd_abort <= 1'b1; // [R3] [R19]
              irq <= 1'b1; // [R3]
              cmd_done <= 1'b1;
            end else begin
              case (cmd_code) // [R13]
                `CMD_READ_DESC: begin
                  cmd_result <= descriptor; // [R17]
                  cmd_done <= 1'b1;
                end
                `CMD_SET_LOCK: begin
                  lock_reg[region_of(cmd_arg)] <= 1'b1; // [R4]
                  cmd_done <= 1'b1;
                end
                `CMD_CLR_LOCK: begin
                  lock_reg[region_of(cmd_arg)] <= 1'b0; // [R4]
                  cmd_done <= 1'b1;
                end
                `CMD_SET_GPBIT: begin
                  gp_reg[cmd_arg[0]] <= 1'b1; // [R11] [R7]
                  cmd_done <= 1'b1;
                end
                `CMD_CLR_GPBIT: begin
                  if (cmd_arg[0] == `GPBIT_BOOT) begin
                    gp_reg[`GPBIT_BOOT] <= 1'b0; // [R11] [R7]
                  end
                  cmd_done <= 1'b1;
                end
                `CMD_PROG_PAGE, `CMD_ERASE_PAGE, `CMD_ERASE_ALL: begin
                  arr_start <= 1'b1;
                  arr_op <= cmd_code[1:0];
                  arr_page <= cmd_arg;
                  arr_wsel <= 3'd0;
                  arr_wdata <= buf_line(wbuf_reg[0], wbuf_reg[1],
                    wbuf_reg[2], wbuf_reg[3]); // [R14]
                  st_reg <= ST_WAIT;
                end
                default: begin
                  cmd_abort <= 1'b1;
                  cmd_done <= 1'b1;
                end
              endcase
            end
          end
        end
        ST_WAIT: begin
          if (arr_done) begin
            cmd_done <= 1'b1;
            st_reg <= ST_IDLE;
            if (full_erase_end && (erase_armed_reg || erase_pin)) begin
              gp_reg[`GPBIT_SECURITY] <= 1'b0; // [R8]
            end
          end
        end
        ST_RDWAIT: begin
          if (arr_done) begin
            rd_data <= pick_word(arr_rdata, rd_word_reg); // [R16]
            rd_valid <= 1'b1;
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
      // erase pin last so it overrides a lock or boot command in the same cycle
      if (erase_pin) begin
        lock_reg <= {REGIONS{1'b0}}; // [R5]
        gp_reg[`GPBIT_BOOT] <= 1'b0; // [R18]
      end
    end
  end

  // ----------------------------------------------------------
  // erase pin monitor
  // ----------------------------------------------------------
  // hold time is counted for visibility only; the security clear
  // needs the pin seen high and a finished erase-all
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      hold_cnt_reg <= 32'h0000_0000;
      erase_armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (erase_pin) begin
        if (hold_cnt_reg < ERASE_HOLD_CYC) begin
          hold_cnt_reg <= hold_cnt_reg + 32'd1;
        end
      end else begin
        hold_cnt_reg <= 32'h0000_0000;
      end
      // a new assertion of the pin wins over the end of an erase-all
      if (erase_pin) begin
        erase_armed_reg <= 1'b1;
      end else if (full_erase_end) begin
        erase_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // fast programming entry
  // ----------------------------------------------------------
  // pins are taken as levels; the mode follows them one cycle later
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      fast_prog_mode <= 1'b0;
    end else if (clk_en) begin
      fast_prog_mode <= test_mode_pin && external_clock_input && !force_wakeup_pin; // [R12]
    end
  end
endmodule // flash_lock_security_nvm
`default_nettype wire

// ==== lock_sva.sv ====
// Purpose: port assertions for the flash protection block
// Assumes: bound to flash_lock_security_nvm, one clock domain
// Notes: checks relations between pins, commands and status outputs
`timescale 1ns/1ps
`default_nettype none
module lock_sva #(parameter REGIONS = 16) (
  // clock, reset and pins
  input wire sys_clk, input wire rst_b, input wire clk_en, input wire erase_pin,
  input wire test_mode_pin, input wire external_clock_input, input wire force_wakeup_pin,
  // watched outputs and the array done input
  input wire cmd_done, input wire cmd_abort, input wire irq, input wire rd_valid,
  input wire rd_denied, input wire arr_done, input wire [REGIONS-1:0] lock_bits,
  input wire [1:0] general_nonvolatile_bits, input wire fast_prog_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_abort;
    cmd_abort && cmd_done;
  endsequence
  a_irq_abort: assert property (irq |-> s_abort) else $error("irq without abort");
  a_erase_locks: assert property (erase_pin && clk_en |=> lock_bits == '0)
    else $error("locks kept under erase");
  a_erase_boot: assert property (erase_pin && clk_en |=> !general_nonvolatile_bits[1])
    else $error("boot bit kept under erase");
  a_secure_kept: assert property ($fell(general_nonvolatile_bits[0])
    |-> $past(arr_done) || $past(arr_done, 2)) else $error("security cleared early");
  a_deny_secure: assert property (rd_denied |-> general_nonvolatile_bits[0])
    else $error("read denied while open");
  a_read_answer: assert property (rd_valid |-> $past(arr_done))
    else $error("read answer before array");
  a_fast_entry: assert property (test_mode_pin && external_clock_input
    && !force_wakeup_pin && clk_en |=> fast_prog_mode) else $error("fast mode not entered");
  a_abort_keeps: assert property (cmd_abort && !$past(erase_pin)
    |-> $stable(lock_bits) && $stable(general_nonvolatile_bits)) else $error("abort changed bits");
endmodule // lock_sva
bind flash_lock_security_nvm lock_sva #(.REGIONS(REGIONS)) u_sva (.sys_clk(sys_clk),
  .rst_b(rst_b), .clk_en(clk_en), .erase_pin(erase_pin), .test_mode_pin(test_mode_pin),
  .external_clock_input(external_clock_input), .force_wakeup_pin(force_wakeup_pin),
  .cmd_done(cmd_done), .cmd_abort(cmd_abort), .irq(irq), .rd_valid(rd_valid),
  .rd_denied(rd_denied), .arr_done(arr_done), .lock_bits(lock_bits),
  .general_nonvolatile_bits(general_nonvolatile_bits), .fast_prog_mode(fast_prog_mode));
`default_nettype wire

// ==== flash_array_model.sv ====
// Purpose: behavioural flash array answering the controller
// Assumes: one request outstanding at a time
// Notes: read data is scrambled outside the answer cycle
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // clock and requests
  input wire sys_clk,
  input wire arr_start,
  input wire arr_rd,
  input wire [31:0] arr_raddr,
  // answer
  output logic [127:0] arr_rdata,
  output logic arr_done
);
  logic [1:0] wait_reg = 2'h0;
  always @(posedge sys_clk) begin
    if (arr_start | arr_rd) wait_reg <= 2'h3;
    else if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
  end
  assign arr_done = (wait_reg == 2'h1);
  assign arr_rdata = arr_done ? {4{arr_raddr}} : ~{4{arr_raddr}};
endmodule // flash_array_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the flash protection block
// Assumes: flash_array_model answers array requests
// Notes: short erase hold parameter lets the hold count saturate during the erase test
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cmd_valid = 1'b0, from_fast = 1'b0;
  logic [3:0] code = 4'h0;
  logic [8:0] arg = 9'h0;
  logic rd_req = 1'b0, rd_debug = 1'b0, rd_fast = 1'b0, erase_pin = 1'b0;
  logic tst = 1'b0, ext_clk = 1'b0, wakeup = 1'b0;
  logic [31:0] rd_addr = 32'h0;
  wire cmd_done, cmd_abort, irq, rd_valid, rd_denied, rom, arr_start, arr_rd, arr_done, fast;
  wire [31:0] result, rd_data, arr_raddr;
  wire [127:0] arr_rdata;
  wire [15:0] locks;
  wire [1:0] gp;
  wire [7:0] cal;
  logic wb_we = 1'b0;
  logic [4:0] wb_addr = 5'h0;
  logic [31:0] wb_data = 32'h0;
  wire [1:0] arr_op;
  wire [8:0] arr_page;
  wire [127:0] arr_wdata;
  wire boot, ready;
  logic [127:0] seen_wdata = 128'h0;
  logic [1:0] seen_op = 2'h0;
  logic [8:0] seen_page = 9'h0;
  // snapshot of each program or erase request (arr_start) as the array sees it
  always @(posedge sys_clk) begin
    if (arr_start) begin
      seen_wdata <= arr_wdata;
      seen_op <= arr_op;
      seen_page <= arr_page;
    end
  end
  int miscompares = 0, samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  flash_lock_security_nvm #(.ERASE_HOLD_CYC(32'h8)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(code), .cmd_arg(arg),
    .cmd_from_fast(from_fast), .cmd_ready(ready), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
    .irq(irq), .cmd_result(result), .wbuf_we(wb_we), .wbuf_addr(wb_addr), .wbuf_wdata(wb_data),
    .rd_req(rd_req), .rd_debug(rd_debug), .rd_fast(rd_fast), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_denied(rd_denied), .rd_data(rd_data), .rd_from_rom(rom),
    .arr_start(arr_start), .arr_op(arr_op), .arr_page(arr_page), .arr_wdata(arr_wdata),
    .arr_wsel(),
    .arr_rd(arr_rd), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_done(arr_done),
    .erase_pin(erase_pin), .test_mode_pin(tst), .external_clock_input(ext_clk),
    .force_wakeup_pin(wakeup), .lock_bits(locks), .general_nonvolatile_bits(gp),
    .calibration_bits(cal), .fast_prog_mode(fast), .boot_from_flash(boot));
  flash_array_model partner (.sys_clk(sys_clk), .arr_start(arr_start), .arr_rd(arr_rd),
    .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_done(arr_done));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // releases the request after the taking edge and waits for the answer
  task automatic wait_ans(input logic is_rd);
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      rd_req <= 1'b0;
      #1;
      if (is_rd ? (rd_valid | rd_denied) : cmd_done) return;
    end
    miscompares++;
    tally_and_finish;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [8:0] a, input logic ab);
    @(posedge sys_clk);
    code <= c;
    arg <= a;
    cmd_valid <= 1'b1;
    wait_ans(1'b0);
    chk("abort", 32'(ab), 32'(cmd_abort));
    chk("irq", 32'(ab && !from_fast && (c == 4'h1 || c == 4'h2)), 32'(irq));
  endtask
  task automatic wbuf_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_we <= 1'b1;
    wb_addr <= a;
    wb_data <= d;
    @(posedge sys_clk);
    wb_we <= 1'b0;
  endtask
  task automatic rd(input logic dbg, input logic fst, input logic [31:0] a, input logic den);
    @(posedge sys_clk);
    rd_debug <= dbg;
    rd_fast <= fst;
    rd_addr <= a;
    rd_req <= 1'b1;
    wait_ans(1'b1);
    chk("denied", 32'(den), 32'(rd_denied));
    if (!den && a[20]) chk("rd_data", a & 32'hffff_fff0, rd_data);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    cmd(4'h4, 9'h000, 0);
    cmd(4'h4, 9'h1e0, 0);
    chk("locks", 32'h8001, 32'(locks));
    cmd(4'h1, 9'h000, 1);
    cmd(4'h2, 9'h01f, 1);
    chk("locks kept", 32'h8001, 32'(locks));
    cmd(4'h2, 9'h020, 0);
    cmd(4'h5, 9'h000, 0);
    for (int i = 0; i < 4; i++) wbuf_write(5'(i), 32'h0000_00a0 + 32'(i));
    cmd(4'h1, 9'h005, 0);
    chk("wdata w0", 32'h0000_00a0, seen_wdata[31:0]);
    chk("wdata w3", 32'h0000_00a3, seen_wdata[127:96]);
    chk("arr op", 32'h1, 32'(seen_op));
    chk("arr page", 32'h5, 32'(seen_page));
    chk("ready", 32'h1, 32'(ready));
    cmd(4'h9, 9'h000, 1);
    cmd(4'h0, 9'h000, 0);
    chk("descriptor", 32'h0010_0100, result);
    $display("test locks done");
    cmd(4'h6, 9'h001, 0);
    chk("boot set", 32'h2, 32'(gp));
    chk("boot out", 32'h1, 32'(boot));
    cmd(4'h7, 9'h001, 0);
    rd(0, 0, 32'h0, 0);
    chk("rom", 32'h1, 32'(rom));
    cmd(4'h6, 9'h001, 0);
    cmd(4'h6, 9'h000, 0);
    cmd(4'h7, 9'h000, 0);
    chk("gp", 32'h3, 32'(gp));
    from_fast <= 1'b1;
    cmd(4'h4, 9'h040, 1);
    from_fast <= 1'b0;
    chk("fast locks", 32'h8000, 32'(locks));
    rd(1, 0, 32'h0010_0024, 1);
    rd(0, 1, 32'h0010_0024, 1);
    rd(0, 0, 32'h0010_0024, 0);
    $display("test security done");
    cmd(4'h4, 9'h060, 0);
    clk_en <= 1'b0;
    erase_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("frozen locks", 32'h8008, 32'(locks));
    clk_en <= 1'b1;
    @(posedge sys_clk);
    erase_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("locks erased", 32'h0, 32'(locks));
    chk("gp erased", 32'h1, 32'(gp));
    cmd(4'h4, 9'h000, 0);
    chk("erase wins", 32'h0, 32'(locks));
    cmd(4'h3, 9'h000, 0);
    chk("gp cleared", 32'h0, 32'(gp));
    chk("cal", 32'h5a, 32'(cal));
    @(posedge sys_clk);
    erase_pin <= 1'b0;
    rd(1, 0, 32'h0010_0010, 0);
    $display("test erase done");
    @(posedge sys_clk);
    tst <= 1'b1;
    ext_clk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("fast", 32'h1, 32'(fast));
    $display("test fast mode done");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
